/* File: hdl/sadc_pkg.sv */
// Package of constants and carrier types for the sampling converter control block
package sadc_pkg;
	localparam int RESULT_W     = 12;
	localparam int SER_WORD_W   = 16;
	localparam int SER_LEAD_W   = 4;
	localparam int BYTE_W       = 8;
	localparam int NIB_W        = 4;
	localparam int CNT_W        = 5;
	localparam int FIFO_W       = 12;
	localparam int FIFO_D       = 32;
	localparam int CLK_HZ       = 10_000_000;
	localparam int CONV_CLK_HZ  = 2_500_000;
	// Conversion clock divider: system cycles per half conversion clock period
	localparam int CCLK_HALF    = CLK_HZ / (2 * CONV_CLK_HZ);
	localparam int STROBE_DLY   = 3;
	localparam int DIV_W        = 4;

	typedef enum logic [1:0] {
		SADC_FMT_PAR12,
		SADC_FMT_SER_GATED,
		SADC_FMT_SER_CONT
	} sadc_fmt_e;

	typedef enum logic [1:0] {
		SADC_IDLE,
		SADC_CONV,
		SADC_DONE
	} sadc_state_e;

	typedef struct packed {
		logic convert_start_n;
		logic chip_select_n;
		logic read_strobe_n;
	} sadc_bus_s;

	typedef struct packed {
		logic frame_oe;
		logic sclk_oe;
		logic data_oe;
	} sadc_ser_s;
endpackage

/* File: hdl/sadc_fifo.sv */
// Parameterised valid/ready FIFO holding conversion results
`timescale 1ns/1ns
module sadc_fifo #(
	parameter int W = 12,
	parameter int D = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} sadc_fifo_s;
	sadc_fifo_s st_ff;
	sadc_fifo_s nxt_st;
	logic [W-1:0] mem_ff [D];
	logic push;
	logic pop;

	assign in_ready  = (st_ff.cnt != (AW+1)'(D));
	assign out_valid = (st_ff.cnt != '0);
	assign out_data  = mem_ff[st_ff.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.wp = (st_ff.wp == AW'(D - 1)) ? '0 : st_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_st.rp = (st_ff.rp == AW'(D - 1)) ? '0 : st_ff.rp + 1'b1;
		end
		nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
		if (push) begin
			mem_ff[st_ff.wp] <= in_data;
		end
	end
endmodule

/* File: hdl/sadc_ctrl.sv */
// Conversion control, result latch and parallel, byte and serial output
//
// Notes on behaviour
// RULE1: Mode 1 starts on convert start rising edge
// RULE2: No convert-start conversion while chip select low
// RULE3: Track-and-hold returns to tracking at completion
// RULE4: Mode 1 status idles high, low at completion
// RULE5: Mode 1 status cleared by first read
// RULE6: Host keeps convert start high during reads
// RULE7: Host drives chip select and read actively
// RULE8: Output latches disabled during conversion
// RULE9: Power-up low status cleared by dummy read
// RULE10: Mode 2 chip select starts, status stalls host
// RULE11: Format select picks parallel or byte/serial
// RULE12: Byte format: low byte or zero-padded nibble
// RULE13: Parallel format gives all bits at once
// RULE14: Serial word: four zeros then result, MSB first
// RULE15: Shift on rising clock, sample on falling
// RULE16: Strobe low within three conversion clocks
// RULE17: Serial pins only pull low or release
// RULE18: Serial clock continuous or gated by format
// RULE19: Upper data lines become serial pins, byte select
// RULE20: No serial output in parallel format
// RULE21: First byte read clears status, either byte
// RULE22: Mode 2 status low throughout conversion
// RULE23: Host holds byte select low at Mode 2 start
// RULE24: Mode 2 hold taken at chip select fall
// RULE25: One conversion clock per result bit
`timescale 1ns/1ns
module sadc_ctrl
	import sadc_pkg::*;
#(
	parameter int RES_W = 12,
	parameter int DEPTH = 32
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire sadc_pkg::sadc_bus_s  bus_in,
	input  wire sadc_pkg::sadc_fmt_e  format_select,
	input  wire logic                 mode2_sel,
	input  wire logic                 high_byte_select,
	input  wire logic [RES_W-1:0]     sar_bits,
	output logic                      track_hold,
	output logic                      status_n,
	output logic [RES_W-1:0]          data_out,
	output logic                      data_oe,
	output sadc_pkg::sadc_ser_s       ser_oe,
	output logic                      serial_frame_strobe_n,
	output logic                      serial_clock_out,
	output logic                      serial_data_out,
	output logic                      result_valid,
	input  wire logic                 result_ready,
	output logic [RES_W-1:0]          result_data
);
	typedef struct packed {
		sadc_state_e       state;
		logic              cs_d;
		logic              cv_d;
		logic              rd_act;
		logic              hold;
		logic              status_n;
		logic [DIV_W-1:0]  div;
		logic              cclk;
		logic [CNT_W-1:0]  step;
		logic [RES_W-1:0]  result;
		logic [RES_W-1:0]  out_q;
		logic              oe;
		logic [CNT_W-1:0]  sbits;
		logic              frame_n;
		logic              sclk;
		logic              sdat;
		logic              push;
	} sadc_st_s;

	sadc_st_s st_ff;
	sadc_st_s nxt_st;
	logic     start_cv;
	logic     start_cs;
	logic     read_fall;
	logic     rd_now;
	logic     tick_rise;
	logic     tick_fall;
	logic     fifo_in_ready;
	logic     ser_en;
	logic [SER_WORD_W-1:0] ser_src;

	// Parallel format gives the whole word; byte format mux chosen by select
	function automatic logic [RES_W-1:0] out_word(input sadc_fmt_e f, input logic hb,
		input logic [RES_W-1:0] r);
		logic [RES_W-1:0] w;
		w = '0;
		if (f == SADC_FMT_PAR12) begin
			w = r; // [RULE13]
		end else if (hb) begin
			w[NIB_W-1:0] = r[RES_W-1:BYTE_W]; // [RULE12] [RULE19]
		end else begin
			w[BYTE_W-1:0] = r[BYTE_W-1:0]; // [RULE12]
		end
		return w;
	endfunction

	assign rd_now    = !bus_in.chip_select_n && !bus_in.read_strobe_n;
	assign read_fall = rd_now && !st_ff.rd_act;
	// Convert start rising edge ignored while chip select is low
	assign start_cv  = !mode2_sel && bus_in.convert_start_n && !st_ff.cv_d
		&& bus_in.chip_select_n; // [RULE1] [RULE2]
	// A select fall with the high byte chosen is a plain read, not a start
	assign start_cs  = mode2_sel && !bus_in.chip_select_n && st_ff.cs_d
		&& !high_byte_select; // [RULE10] [RULE24]
	assign tick_rise = (st_ff.div == DIV_W'(CCLK_HALF - 1)) && !st_ff.cclk;
	assign tick_fall = (st_ff.div == DIV_W'(CCLK_HALF - 1)) && st_ff.cclk;
	assign ser_en    = (format_select != SADC_FMT_PAR12); // [RULE11] [RULE20]
	// Word bits follow the live comparator result until it is latched
	assign ser_src   = SER_WORD_W'({SER_LEAD_W'(0),
		(st_ff.state == SADC_CONV) ? sar_bits : st_ff.result}) << st_ff.sbits; // [RULE14]

	always_comb begin
		nxt_st = st_ff;
		nxt_st.cs_d   = bus_in.chip_select_n;
		nxt_st.cv_d   = bus_in.convert_start_n;
		nxt_st.rd_act = rd_now;
		nxt_st.push   = 1'b0;
		nxt_st.div    = (st_ff.div == DIV_W'(CCLK_HALF - 1)) ? '0 : st_ff.div + 1'b1;
		if (st_ff.div == DIV_W'(CCLK_HALF - 1)) begin
			nxt_st.cclk = !st_ff.cclk;
		end
		// Serial frame opens on the first conversion clock rise of a conversion
		if (tick_rise) begin
			nxt_st.sclk = 1'b1;
			if (!st_ff.frame_n && st_ff.sbits == CNT_W'(SER_WORD_W)) begin
				// Strobe stays low through the last falling edge
				nxt_st.frame_n = 1'b1;
				nxt_st.sdat    = 1'b1;
			end else if (!st_ff.frame_n || (ser_en && st_ff.state == SADC_CONV
				&& st_ff.sbits == '0)) begin
				nxt_st.frame_n = 1'b0; // [RULE16]
				nxt_st.sdat    = ser_src[SER_WORD_W-1]; // [RULE14] [RULE15]
				nxt_st.sbits   = st_ff.sbits + 1'b1;
			end
		end
		if (tick_fall) begin
			nxt_st.sclk = 1'b0;
		end
		unique case (st_ff.state)
			SADC_IDLE, SADC_DONE: begin
				if (start_cv || start_cs) begin
					nxt_st.state   = SADC_CONV;
					nxt_st.hold    = 1'b1; // [RULE1] [RULE24]
					nxt_st.step    = '0;
					nxt_st.oe      = 1'b0; // [RULE8]
					nxt_st.sbits   = '0;
					nxt_st.frame_n = 1'b1;
					nxt_st.sdat    = 1'b1;
					nxt_st.status_n = mode2_sel ? 1'b0 : 1'b1; // [RULE22]
				end else if (read_fall) begin
					nxt_st.out_q    = out_word(format_select, high_byte_select, st_ff.result);
					nxt_st.oe       = 1'b1;
					if (!mode2_sel) begin
						nxt_st.status_n = 1'b1; // [RULE5] [RULE9] [RULE21]
					end
				end else if (!rd_now) begin
					nxt_st.oe = 1'b0;
				end
			end
			SADC_CONV: begin
				nxt_st.oe = 1'b0; // [RULE8]
				if (tick_fall) begin
					if (st_ff.step == CNT_W'(RES_W - 1)) begin
						nxt_st.state    = SADC_DONE;
						nxt_st.hold     = 1'b0; // [RULE3]
						nxt_st.result   = sar_bits; // [RULE25]
						nxt_st.status_n = mode2_sel ? 1'b1 : 1'b0; // [RULE4] [RULE22]
						nxt_st.push     = fifo_in_ready;
					end else begin
						nxt_st.step = st_ff.step + 1'b1; // [RULE25]
					end
				end
			end
		endcase
		if (!ser_en) begin
			nxt_st.frame_n = 1'b1; // [RULE20]
			nxt_st.sdat    = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff          <= '0;
			st_ff.state    <= SADC_IDLE;
			st_ff.status_n <= 1'b1;
			st_ff.cs_d     <= 1'b1;
			st_ff.cv_d     <= 1'b1;
			st_ff.frame_n  <= 1'b1;
			st_ff.sdat     <= 1'b1;
			st_ff.sbits    <= CNT_W'(SER_WORD_W);
		end else begin
			st_ff <= nxt_st;
		end
	end

	sadc_fifo #(
		.W (RES_W),
		.D (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (st_ff.push),
		.in_ready  (fifo_in_ready),
		.in_data   (st_ff.result),
		.out_valid (result_valid),
		.out_ready (result_ready),
		.out_data  (result_data)
	);

	assign track_hold = st_ff.hold;
	assign status_n   = st_ff.status_n;
	assign data_out   = st_ff.out_q;
	assign data_oe    = st_ff.oe;
	// Clock gated to the frame unless continuous format selected
	assign serial_clock_out = (format_select == SADC_FMT_SER_CONT || !st_ff.frame_n)
		? st_ff.sclk : 1'b1; // [RULE18]
	assign serial_frame_strobe_n = st_ff.frame_n;
	assign serial_data_out = st_ff.sdat;
	assign ser_oe.frame_oe = ser_en && !st_ff.frame_n; // [RULE17]
	assign ser_oe.sclk_oe  = ser_en && !serial_clock_out; // [RULE17]
	assign ser_oe.data_oe  = ser_en && !st_ff.sdat; // [RULE17]
endmodule

/* File: bench/sadc_ctrl_chk.sv */
// Port checker for the converter control block
`timescale 1ns/1ns
module sadc_ctrl_chk
	import sadc_pkg::*;
(
	input wire logic                clk,
	input wire logic                rst_b,
	input wire sadc_pkg::sadc_bus_s bus_in,
	input wire sadc_pkg::sadc_fmt_e format_select,
	input wire logic                mode2_sel,
	input wire logic                high_byte_select,
	input wire logic                track_hold,
	input wire logic                status_n,
	input wire logic                data_oe,
	input wire sadc_pkg::sadc_ser_s ser_oe,
	input wire logic                serial_frame_strobe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire m1 = !mode2_sel && !track_hold;
	cs_start_a: assert property (m1 && $rose(bus_in.convert_start_n) && bus_in.chip_select_n
		|=> track_hold) else $error("no hold after start");
	cs_block_a: assert property (m1 && $rose(bus_in.convert_start_n) && !bus_in.chip_select_n
		|=> !track_hold) else $error("start taken while selected");
	m2_hold_a: assert property (mode2_sel && !track_hold && !high_byte_select
		&& $fell(bus_in.chip_select_n) |=> track_hold) else $error("no hold at select fall");
	m2_hbs_a: assert property (mode2_sel && !track_hold && high_byte_select
		&& $fell(bus_in.chip_select_n) |=> !track_hold) else $error("high byte read started");
	conv_len_a: assert property ($rose(track_hold) |=> (track_hold throughout ##40 1)
		##[1:16] !track_hold) else $error("conversion length wrong");
	irq_set_a: assert property (!mode2_sel && $fell(track_hold) |-> !status_n)
		else $error("end of conversion not flagged");
	oe_off_a: assert property (track_hold |-> !data_oe)
		else $error("data enabled in conversion");
	rd_clr_a: assert property (m1 && !status_n && !bus_in.chip_select_n && !bus_in.read_strobe_n
		|=> status_n && data_oe) else $error("read did not clear status");
	par_quiet_a: assert property (format_select == SADC_FMT_PAR12 |-> ser_oe == '0)
		else $error("serial active in parallel format");
	strobe_dly_a: assert property ($rose(track_hold) && format_select != SADC_FMT_PAR12
		|-> ##[1:14] !serial_frame_strobe_n) else $error("frame strobe late");
endmodule
bind sadc_ctrl sadc_ctrl_chk i_sadc_ctrl_chk (.clk, .rst_b, .bus_in, .format_select, .mode2_sel,
	.high_byte_select, .track_hold, .status_n, .data_oe, .ser_oe, .serial_frame_strobe_n);

/* File: bench/sadc_host.sv */
// Host model: bus master for starts and reads, serial receiver
`timescale 1ns/1ns
module sadc_host
	import sadc_pkg::*;
(
	input wire logic        clk,
	input wire logic        serial_clock_out,
	input wire logic        serial_frame_strobe_n,
	input wire logic        serial_data_out,
	input wire logic [11:0] data_out,
	input wire logic        data_oe,
	output sadc_pkg::sadc_bus_s bus_in,
	output logic            high_byte_select,
	output logic [15:0]     ser_word,
	output logic [11:0]     got,
	output logic            got_oe
);
	initial begin
		bus_in = '1;
		high_byte_select = 1'b0;
		ser_word = '0;
	end
	always @(negedge serial_clock_out) begin
		if (!serial_frame_strobe_n) begin
			ser_word <= {ser_word[14:0], serial_data_out};
		end
	end
	task automatic start(input logic m2);
		@(posedge clk);
		if (m2) begin
			bus_in <= '{1'b0, 1'b0, 1'b1};
		end else begin
			bus_in.convert_start_n <= 1'b0;
			@(posedge clk);
			bus_in.convert_start_n <= 1'b1;
		end
	endtask
	// Convert start is left at its level, low after a Mode 2 start; select and strobe are always driven back high
	task automatic rd(input logic hbs, input int hold);
		@(posedge clk);
		high_byte_select <= hbs;
		bus_in.chip_select_n <= 1'b0;
		bus_in.read_strobe_n <= 1'b0;
		repeat (hold) @(negedge clk);
		got = data_out;
		got_oe = data_oe;
		@(posedge clk);
		bus_in.chip_select_n <= 1'b1;
		bus_in.read_strobe_n <= 1'b1;
	endtask
endmodule

/* File: bench/tb_sadc_ctrl.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_sadc_ctrl;
	import sadc_pkg::*;
	logic clk, rst_b, mode2_sel, high_byte_select, result_ready, got_oe;
	logic track_hold, status_n, data_oe, result_valid;
	logic serial_frame_strobe_n, serial_clock_out, serial_data_out;
	logic [11:0] sar_bits, data_out, result_data, got, last;
	logic [15:0] ser_word;
	sadc_bus_s bus_in;
	sadc_ser_s ser_oe;
	sadc_fmt_e format_select;
	int fails, checks_done, n;
	sadc_ctrl #(.RES_W(12), .DEPTH(32)) i_sadc_ctrl (.clk, .rst_b, .bus_in, .format_select,
		.mode2_sel, .high_byte_select, .sar_bits, .track_hold, .status_n, .data_out, .data_oe,
		.ser_oe, .serial_frame_strobe_n, .serial_clock_out, .serial_data_out, .result_valid,
		.result_ready, .result_data);
	sadc_host i_sadc_host (.clk, .serial_clock_out, .serial_frame_strobe_n, .serial_data_out,
		.data_out, .data_oe, .bus_in, .high_byte_select, .ser_word, .got, .got_oe);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("fails=%0d checks_done=%0d", fails, checks_done);
		if (fails == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] e, input logic [15:0] a);
		@(negedge clk);
		checks_done++;
		if (a !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic wait_st(input logic lvl);
		int k;
		for (k = 0; k < 200 && status_n !== lvl; k++) begin
			@(negedge clk);
		end
		if (status_n !== lvl) begin
			fails++;
			tally_and_finish();
		end
	endtask
	// Counts level changes of the serial clock over 40 cycles
	task automatic moves(output int m);
		logic p;
		m = 0;
		p = serial_clock_out;
		repeat (40) begin
			@(negedge clk);
			m += int'(serial_clock_out != p);
			p = serial_clock_out;
		end
	endtask
	task automatic conv(input logic [11:0] v, input logic m2);
		sar_bits <= v;
		i_sadc_host.start(m2);
		wait_st(1'b0);
	endtask
	initial begin
		rst_b = 1'b0;
		mode2_sel = 1'b0;
		result_ready = 1'b0;
		sar_bits = '0;
		format_select = SADC_FMT_PAR12;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		i_sadc_host.rd(1'b0, 2);
		conv(12'hA5C, 1'b0);
		i_sadc_host.rd(1'b0, 2);
		chk(16'h1A5C, {3'h0, got_oe, got});
		chk(16'h0001, 16'(status_n));
		i_sadc_host.bus_in.chip_select_n <= 1'b0;
		i_sadc_host.start(1'b0);
		repeat (2) @(posedge clk);
		chk(16'h0000, 16'(track_hold));
		i_sadc_host.bus_in.chip_select_n <= 1'b1;
		format_select <= SADC_FMT_SER_GATED;
		conv(12'h3C7, 1'b0);
		i_sadc_host.rd(1'b1, 2);
		chk(16'h0003, {8'h0, got[7:0]});
		chk(16'h0001, 16'(status_n));
		i_sadc_host.rd(1'b0, 2);
		chk(16'h00C7, {8'h0, got[7:0]});
		repeat (80) @(posedge clk);
		chk(16'h03C7, ser_word);
		moves(n);
		chk(16'h0000, 16'(n));
		chk(16'h0000, 16'(ser_oe));
		format_select <= SADC_FMT_SER_CONT;
		moves(n);
		chk(16'h0001, 16'(n > 0));
		// Fill the result buffer past its depth with the consumer stalled
		for (int i = 0; i < 33; i++) begin
			conv(12'(i), 1'b0);
			i_sadc_host.rd(1'b0, 2);
		end
		result_ready <= 1'b1;
		n = 0;
		repeat (40) begin
			@(negedge clk);
			if (result_valid === 1'b1) begin
				n++;
				last = result_data;
			end
		end
		chk(16'd32, 16'(n));
		chk(16'd29, {4'h0, last});
		mode2_sel <= 1'b1;
		conv(12'h5E1, 1'b1);
		wait_st(1'b1);
		i_sadc_host.rd(1'b0, 2);
		chk(16'h00E1, {8'h0, got[7:0]});
		i_sadc_host.rd(1'b1, 2);
		chk(16'h0005, {8'h0, got[7:0]});
		chk(16'h0000, 16'(track_hold));
		tally_and_finish();
	end
endmodule
